// file: hdl/idec_cfg.svh
// constants for the instruction decoder: field positions, opcode groups and table values
`ifndef IDEC_CFG_SVH
`define IDEC_CFG_SVH

`define IDEC_BYTE_W       8
`define IDEC_WORD_W       16
`define IDEC_SEG_W        2
`define IDEC_TRAP_W       7
`define IDEC_LEN_SHORT    3'h2
`define IDEC_LEN_LONG     3'h4
// low nibble patterns
`define IDEC_LO_RELBR     4'h_d
`define IDEC_LO_BIT_CLEAR_INSTR      4'h_e
`define IDEC_LO_BIT_SET_INSTR      4'h_f
`define IDEC_LO_SHORTF    3'h0
// short-form operand field boundaries
`define IDEC_SF_IND_MIN   4'h8
`define IDEC_SF_INC_MIN   4'h_c
// opcodes with a named role
`define IDEC_OP_ZXT_RR    8'h_c0
`define IDEC_OP_ZXT_RM    8'h_c2
`define IDEC_OP_ZXT_MR    8'h_c5
`define IDEC_OP_BTC       8'h_aa
`define IDEC_OP_BTS       8'h_ba
`define IDEC_OP_JB        8'h8a
`define IDEC_OP_JNB       8'h9a
`define IDEC_OP_PUSH_AND_CALL     8'h_e2
`define IDEC_OP_CONTEXT_SWITCH_PUSH_IMM  8'h_c6
`define IDEC_OP_CONTEXT_SWITCH_PUSH_MEM  8'h_d6
`define IDEC_OP_RETURN_WITH_POP      8'h_eb
`define IDEC_OP_FAR_CALL     8'h_da
`define IDEC_OP_FAR_RETURN      8'h_db
`define IDEC_OP_JMPS      8'h_fa
`define IDEC_OP_JMPA      8'h_ea
`define IDEC_OP_CALLA     8'h_ca
`define IDEC_OP_TRAP      8'h9b
`define IDEC_OP_POWER_DOWN_INSTR     8'h97
`define IDEC_OP_END_OF_INIT_INSTR     8'h_b5
`define IDEC_OP_SOFTWARE_RESET_INSTR      8'h_b7
`define IDEC_OP_WATCHDOG_SERVICE_INSTR    8'h_a7
`define IDEC_OP_WATCHDOG_DISABLE_INSTR    8'h_a5
`define IDEC_OP_IDLE      8'h87
`define IDEC_OP_BFLDL     8'h0a
`define IDEC_OP_BFLDH     8'h1a
`define IDEC_OP_MUL       8'h0b
`define IDEC_OP_MULU      8'h1b
`define IDEC_OP_DIVL      8'h6b
`define IDEC_OP_DIVLU     8'h7b
// undefined opcodes: one bit per opcode, bit n set means opcode n traps
`define IDEC_UNDEF_MAP    256'h_0320_0028_108A_008A_0008_0008_0028_1828_0000_0000_0000_0030_0800_0000_0000_0000
// two-byte forms: one bit per opcode, clear means four bytes
`define IDEC_LEN2_MAP     256'h_FB03_FB03_FB03_FB03_FB03_FB03_FB03_FB03_FB03_FB03_FB03_FB03_FB03_FB03_FB03_FB03
`endif

// file: hdl/idec_pkg.sv
// types shared by the instruction decoder modules
package idec_pkg;
  typedef enum logic [4:0] {
    IDEC_CC_UC, IDEC_NOT_EQUAL_NOT_TABLE_END, IDEC_CC_Z, IDEC_CC_NZ, IDEC_CC_V, IDEC_CC_NV, IDEC_CC_N,
    IDEC_CC_NN, IDEC_CC_C, IDEC_CC_NC, IDEC_CC_SGT, IDEC_CC_SLE, IDEC_CC_SLT,
    IDEC_CC_SGE, IDEC_CC_UGT, IDEC_CC_ULE
  } idec_cc_t;

  typedef struct packed {
    logic z;
    logic c;
    logic v;
    logic n;
    logic e;
  } idec_flags_t;

  typedef enum logic [1:0] {
    IDEC_SF_IMM3, IDEC_SF_IND, IDEC_SF_INC
  } idec_sfmode_t;

  typedef enum logic [3:0] {
    IDEC_CL_ALU, IDEC_CL_MOVE, IDEC_CL_JUMP, IDEC_CL_CALL, IDEC_CL_STACK,
    IDEC_CL_RET, IDEC_CL_SYS, IDEC_CL_BIT, IDEC_CL_MULDIV, IDEC_CL_TRAP
  } idec_class_t;

  typedef struct packed {
    idec_class_t  iclass;
    logic         zero_ext;
    logic         bit_clr_on_one;
    logic         bit_set_on_zero;
    logic         push_first;
    logic         load_seg;
    logic         pop_seg;
    logic         pop_reg;
    logic         sw_trap;
    logic [6:0]   trap_num;
    logic         power_down;
    logic         end_init;
    logic         byte_op;
    logic         sfr_low_only;
    logic         ptr_r0_r3;
    logic         md_implicit;
    logic         bitfield;
    logic [3:0]   bit_pos;
    logic [7:0]   bf_mask;
    logic [7:0]   bf_data;
    idec_sfmode_t sf_mode;
    logic [15:0]  imm;
    logic         undef_trap;
    logic         branch_taken;
    logic [15:0]  target_ip;
    logic [1:0]   target_seg;
    logic [15:0]  result;
  } idec_ctrl_t;
endpackage

// file: hdl/idec_cond.sv
// branch condition evaluator over the current flags
`timescale 1ns/1ps
module idec_cond
  import idec_pkg::*;
(
  input  wire logic [3:0]  cc,
  input  idec_flags_t      flags,
  output logic             met
);
  // condition codes follow the opcode high nibble layout of the short branch
  always_comb begin
    case (idec_cc_t'({1'b0, cc}))
      IDEC_CC_UC:  met = 1'b1;
      IDEC_CC_Z:   met = flags.z;
      IDEC_CC_NZ:  met = ~flags.z;
      IDEC_CC_V:   met = flags.v;
      IDEC_CC_NV:  met = ~flags.v;
      IDEC_CC_N:   met = flags.n;
      IDEC_CC_NN:  met = ~flags.n;
      IDEC_CC_C:   met = flags.c;
      IDEC_CC_NC:  met = ~flags.c;
      IDEC_CC_SGT: met = ~flags.z & ~(flags.n ^ flags.v);
      IDEC_CC_SLE: met = flags.z | (flags.n ^ flags.v);
      IDEC_CC_SLT: met = flags.n ^ flags.v;
      IDEC_CC_SGE: met = ~(flags.n ^ flags.v);
      IDEC_CC_UGT: met = ~flags.z & ~flags.c;
      IDEC_CC_ULE: met = flags.z | flags.c;
      IDEC_NOT_EQUAL_NOT_TABLE_END: met = ~flags.z & ~flags.e;
      default:     met = 1'b0;
    endcase
  end
endmodule

// file: hdl/idec_imm.sv
// immediate field extractor sized by the instruction form
`timescale 1ns/1ps
module idec_imm (
  input  wire logic [1:0]  size_sel,
  input  wire logic [7:0]  op1,
  input  wire logic [15:0] word,
  output logic      [15:0] imm
);
  // 0: 3 bits, 1: 4 bits, 2: 8 bits, 3: 16 bits
  always_comb begin
    case (size_sel)
      2'h0:    imm = {13'h0000, op1[2:0]};
      2'h1:    imm = {12'h000, op1[7:4]};
      2'h2:    imm = {8'h00, word[7:0]};
      default: imm = word;
    endcase
  end
endmodule

// file: hdl/idec_top.sv
// instruction decoder: classifies opcodes, extracts fields, resolves branches
`timescale 1ns/1ps
`include "idec_cfg.svh"
module idec_top
  import idec_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        INSTR_VALID,
  input  wire logic [31:0] INSTR,
  input  wire logic [15:0] IP,
  input  idec_flags_t      FLAGS,
  input  wire logic        TEST_BIT,
  input  wire logic [15:0] SRC_BYTE_WORD,
  input  wire logic [15:0] BF_WORD,
  input  wire logic        BF_HIGH_SEL,
  input  wire logic        NMI_LEVEL,
  output logic [2:0]       INSTR_LEN,
  output logic             CTRL_VALID,
  output idec_ctrl_t       CTRL,
  output logic             RESET_OUTPUT_PIN_LEVEL
);
  logic [7:0]  op;
  logic [7:0]  op1;
  logic [15:0] word2;
  logic [3:0]  lo;
  logic [3:0]  hi;
  logic        is_undef;
  logic        cond_met;
  logic [3:0]  cc_sel;
  logic [1:0]  imm_sel;
  logic [15:0] imm_val;
  logic [15:0] next_ip;
  logic [15:0] rel_off;
  idec_ctrl_t  next_ctrl;
  logic        end_of_init_instr_seen;

  assign op    = INSTR[7:0];
  assign op1   = INSTR[15:8];
  assign word2 = INSTR[31:16];
  assign lo    = op[3:0];
  assign hi    = op[7:4];

  // length and trap come from the first byte only, before operand fetch
  logic [255:0] len2_map;
  logic [255:0] undef_map;
  assign len2_map  = `IDEC_LEN2_MAP;
  assign undef_map = `IDEC_UNDEF_MAP;
  assign is_undef  = undef_map[op];
  assign INSTR_LEN = len2_map[op] ? `IDEC_LEN_SHORT : `IDEC_LEN_LONG;

  // condition source: short branch uses opcode nibble, others op1 high nibble
  assign cc_sel = (lo == `IDEC_LO_RELBR) ? hi : op1[7:4];

  idec_cond u_cond (
    .cc    (cc_sel),
    .flags (FLAGS),
    .met   (cond_met)
  );

  // immediate width by form
  always_comb begin
    if (op[2:0] == `IDEC_LO_SHORTF && lo != 4'h0) begin
      imm_sel = 2'h0;
    end else if ((op[3:0] == 4'h0 && hi >= 4'h8) || lo == 4'h_c || op == 8'h_e1) begin
      imm_sel = 2'h1;
    end else if (op[0] && (lo == 4'h7)) begin
      imm_sel = 2'h2;
    end else begin
      imm_sel = 2'h3;
    end
  end

  idec_imm u_imm (
    .size_sel (imm_sel),
    .op1      (op1),
    .word     (word2),
    .imm      (imm_val)
  );

  // relative offset: word offset from the following instruction
  assign next_ip = IP + {13'h0000, INSTR_LEN};
  always_comb begin
    if (lo == `IDEC_LO_RELBR || op == 8'h_bb) begin
      rel_off = {{7{op1[7]}}, op1, 1'b0};
    end else begin
      rel_off = {{7{word2[15]}}, word2[15:8], 1'b0};
    end
  end

  // combinational decode of one instruction
  always_comb begin
    next_ctrl            = '0;
    next_ctrl.iclass     = IDEC_CL_ALU;
    next_ctrl.undef_trap = is_undef;
    next_ctrl.imm        = (imm_sel == 2'h0) ? {13'h0000, op1[2:0]} : imm_val;
    next_ctrl.target_ip  = next_ip;
    next_ctrl.byte_op    = op[0] & (hi < 4'h_8) & (lo != 4'h_d) & (lo != 4'h_b);
    // short-form operand field modes
    if (op1[3:0] >= `IDEC_SF_INC_MIN) begin
      next_ctrl.sf_mode = IDEC_SF_INC;
    end else if (op1[3:0] >= `IDEC_SF_IND_MIN) begin
      next_ctrl.sf_mode = IDEC_SF_IND;
    end else begin
      next_ctrl.sf_mode = IDEC_SF_IMM3;
    end
    // arithmetic/logic/compare short forms restrict the pointer register
    if (hi < 4'h8 && op[3:1] == 3'h4) begin
      next_ctrl.ptr_r0_r3 = 1'b1;
    end
    // byte ops on a special register address only its low byte
    next_ctrl.sfr_low_only = next_ctrl.byte_op;
    if (lo == `IDEC_LO_BIT_CLEAR_INSTR || lo == `IDEC_LO_BIT_SET_INSTR) begin
      next_ctrl.iclass  = IDEC_CL_BIT;
      next_ctrl.bit_pos = hi;
    end else if (lo == `IDEC_LO_RELBR) begin
      next_ctrl.iclass       = IDEC_CL_JUMP;
      next_ctrl.branch_taken = cond_met;
      next_ctrl.target_ip    = next_ip + rel_off;
    end
    case (op)
      `IDEC_OP_ZXT_RR: begin
        next_ctrl.iclass   = IDEC_CL_MOVE;
        next_ctrl.zero_ext = 1'b1;
        next_ctrl.result   = {8'h00, SRC_BYTE_WORD[7:0]};
      end
      `IDEC_OP_ZXT_RM, `IDEC_OP_ZXT_MR: begin
        next_ctrl.iclass   = IDEC_CL_MOVE;
        next_ctrl.zero_ext = 1'b1;
        next_ctrl.result   = {8'h00, SRC_BYTE_WORD[7:0]};
      end
      `IDEC_OP_BTC: begin
        next_ctrl.iclass         = IDEC_CL_JUMP;
        next_ctrl.branch_taken   = TEST_BIT;
        next_ctrl.bit_clr_on_one = TEST_BIT;
        next_ctrl.target_ip      = next_ip + rel_off;
      end
      `IDEC_OP_BTS: begin
        next_ctrl.iclass          = IDEC_CL_JUMP;
        next_ctrl.branch_taken    = ~TEST_BIT;
        next_ctrl.bit_set_on_zero = ~TEST_BIT;
        next_ctrl.target_ip       = next_ip + rel_off;
      end
      `IDEC_OP_JB, `IDEC_OP_JNB: begin
        next_ctrl.iclass       = IDEC_CL_JUMP;
        next_ctrl.branch_taken = (op == `IDEC_OP_JB) ? TEST_BIT : ~TEST_BIT;
        next_ctrl.target_ip    = next_ip + rel_off;
      end
      `IDEC_OP_PUSH_AND_CALL: begin
        next_ctrl.iclass       = IDEC_CL_CALL;
        next_ctrl.push_first   = 1'b1;
        next_ctrl.branch_taken = 1'b1;
        next_ctrl.target_ip    = word2;
      end
      `IDEC_OP_CONTEXT_SWITCH_PUSH_IMM, `IDEC_OP_CONTEXT_SWITCH_PUSH_MEM: begin
        next_ctrl.iclass     = IDEC_CL_STACK;
        next_ctrl.push_first = 1'b1;
        next_ctrl.imm        = word2;
      end
      `IDEC_OP_RETURN_WITH_POP: begin
        next_ctrl.iclass  = IDEC_CL_RET;
        next_ctrl.pop_reg = 1'b1;
      end
      `IDEC_OP_FAR_CALL, `IDEC_OP_JMPS: begin
        next_ctrl.iclass       = (op == `IDEC_OP_FAR_CALL) ? IDEC_CL_CALL : IDEC_CL_JUMP;
        next_ctrl.load_seg     = 1'b1;
        next_ctrl.branch_taken = 1'b1;
        next_ctrl.target_seg   = op1[1:0];
        next_ctrl.target_ip    = word2;
      end
      `IDEC_OP_FAR_RETURN: begin
        next_ctrl.iclass  = IDEC_CL_RET;
        next_ctrl.pop_seg = 1'b1;
      end
      `IDEC_OP_JMPA, `IDEC_OP_CALLA: begin
        next_ctrl.iclass       = (op == `IDEC_OP_CALLA) ? IDEC_CL_CALL : IDEC_CL_JUMP;
        next_ctrl.branch_taken = cond_met;
        next_ctrl.target_ip    = word2;
      end
      `IDEC_OP_TRAP: begin
        next_ctrl.iclass   = IDEC_CL_TRAP;
        next_ctrl.sw_trap  = 1'b1;
        next_ctrl.trap_num = op1[7:1];
      end
      `IDEC_OP_POWER_DOWN_INSTR: begin
        next_ctrl.iclass     = IDEC_CL_SYS;
        next_ctrl.power_down = ~NMI_LEVEL;
      end
      `IDEC_OP_END_OF_INIT_INSTR: begin
        next_ctrl.iclass   = IDEC_CL_SYS;
        next_ctrl.end_init = 1'b1;
      end
      `IDEC_OP_SOFTWARE_RESET_INSTR, `IDEC_OP_WATCHDOG_SERVICE_INSTR, `IDEC_OP_WATCHDOG_DISABLE_INSTR, `IDEC_OP_IDLE: begin
        next_ctrl.iclass = IDEC_CL_SYS;
      end
      `IDEC_OP_BFLDL, `IDEC_OP_BFLDH: begin
        next_ctrl.iclass   = IDEC_CL_BIT;
        next_ctrl.bitfield = 1'b1;
        next_ctrl.bf_mask  = word2[7:0];
        next_ctrl.bf_data  = word2[15:8];
        if (BF_HIGH_SEL) begin
          next_ctrl.result = {(BF_WORD[15:8] & ~word2[7:0]) | (word2[15:8] & word2[7:0]),
                              BF_WORD[7:0]};
        end else begin
          next_ctrl.result = {BF_WORD[15:8],
                              (BF_WORD[7:0] & ~word2[7:0]) | (word2[15:8] & word2[7:0])};
        end
      end
      `IDEC_OP_MUL, `IDEC_OP_MULU, `IDEC_OP_DIVL, `IDEC_OP_DIVLU, 8'h4b, 8'h5b: begin
        next_ctrl.iclass      = IDEC_CL_MULDIV;
        next_ctrl.md_implicit = 1'b1;
      end
      default: begin
      end
    endcase
    // an undefined opcode never executes
    if (is_undef) begin
      next_ctrl              = '0;
      next_ctrl.iclass       = IDEC_CL_TRAP;
      next_ctrl.undef_trap   = 1'b1;
    end
  end

  // registered decode output
  always_ff @(posedge CLK) begin
    if (RESET) begin
      CTRL       <= '0;
      CTRL_VALID <= 1'b0;
    end else begin
      CTRL       <= INSTR_VALID ? next_ctrl : '0;
      CTRL_VALID <= INSTR_VALID;
    end
  end

  // reset output pin changes state once initialisation ends; stays until reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      end_of_init_instr_seen <= 1'b0;
    end else if (INSTR_VALID && !is_undef && op == `IDEC_OP_END_OF_INIT_INSTR) begin
      end_of_init_instr_seen <= 1'b1;
    end
  end
  assign RESET_OUTPUT_PIN_LEVEL = ~end_of_init_instr_seen; // high during init, low after
endmodule

// file: testbench/idec_top_chk.sv
// port-level assertions for the instruction decoder
`timescale 1ns/1ps
module idec_top_chk
  import idec_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        INSTR_VALID,
  input  wire logic [31:0] INSTR,
  input  wire logic [15:0] IP,
  input  idec_flags_t      FLAGS,
  input  wire logic        TEST_BIT,
  input  wire logic [15:0] SRC_BYTE_WORD,
  input  wire logic [15:0] BF_WORD,
  input  wire logic        BF_HIGH_SEL,
  input  wire logic        NMI_LEVEL,
  input  wire logic [2:0]  INSTR_LEN,
  input  wire logic        CTRL_VALID,
  input  idec_ctrl_t       CTRL,
  input  wire logic        RESET_OUTPUT_PIN_LEVEL
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  logic [7:0]  op;
  logic [15:0] rel_t;
  // relative target worked out from the word that stands this cycle
  assign op = INSTR[7:0];
  assign rel_t = IP + 16'h2 + {{7{INSTR[15]}}, INSTR[15:8], 1'b0};

  property p_len; INSTR_VALID && op[3:0] > 4'hc |-> INSTR_LEN == 3'h2; endproperty
  a_len: assert property (p_len) else $error("short form not two bytes");
  property p_zext; INSTR_VALID && op == 8'hc0 |=>
    CTRL.zero_ext && CTRL.result == {8'h00, $past(SRC_BYTE_WORD[7:0])}; endproperty
  a_zext: assert property (p_zext) else $error("zero extension wrong");
  property p_clr; INSTR_VALID && op == 8'haa |=> CTRL.branch_taken == $past(TEST_BIT)
    && CTRL.bit_clr_on_one == $past(TEST_BIT); endproperty
  a_clr: assert property (p_clr) else $error("test and clear branch wrong");
  property p_set; INSTR_VALID && op == 8'hba |=> CTRL.branch_taken != $past(TEST_BIT)
    && CTRL.bit_set_on_zero != $past(TEST_BIT); endproperty
  a_set: assert property (p_set) else $error("test and set branch wrong");
  property p_rel; INSTR_VALID && op == 8'h0d |=>
    CTRL.branch_taken && CTRL.target_ip == $past(rel_t); endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");
  property p_trap; INSTR_VALID && op == 8'h9b |=>
    CTRL.sw_trap && CTRL.trap_num == $past(INSTR[15:9]); endproperty
  a_trap: assert property (p_trap) else $error("trap number wrong");
  property p_pwr; INSTR_VALID && op == 8'h97 |=> CTRL.power_down != $past(NMI_LEVEL); endproperty
  a_pwr: assert property (p_pwr) else $error("power down gating wrong");
  property p_end_of_init_instr; INSTR_VALID && op == 8'hb5 |-> ##[1:2] !RESET_OUTPUT_PIN_LEVEL; endproperty
  a_end_of_init_instr: assert property (p_end_of_init_instr) else $error("reset output not dropped");
  property p_undef; INSTR_VALID && op inside {8'h8b, 8'hc1, 8'he5, 8'hf5, 8'hf8, 8'h3b}
    |=> CTRL.undef_trap && CTRL.iclass == IDEC_CL_TRAP; endproperty
  a_undef: assert property (p_undef) else $error("undefined opcode not trapped");
endmodule

// file: testbench/idec_pmem.sv
// program memory model: answers each fetch with one instruction word
`timescale 1ns/1ps
module idec_pmem (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        fetch,
  input  wire logic        slow,
  input  wire logic [31:0] word,
  output logic             instr_valid,
  output logic [31:0]      instr
);
  logic        pend;
  logic [31:0] held;
  // a slow fetch waits one cycle; an idle bus inverts its value each cycle, so the stale word returns every second idle cycle
  always_ff @(posedge clk) begin
    pend        <= fetch && slow && !rst;
    held        <= fetch ? word : held;
    instr_valid <= !rst && ((fetch && !slow) || pend);
    instr       <= rst ? 32'h0f0f_0f0f : (fetch && !slow) ? word : pend ? held : ~instr;
  end
endmodule

// file: testbench/idec_tb_top.sv
// self-checking bench for the instruction decoder fed by a program memory model
`timescale 1ns/1ps
module idec_tb_top
  import idec_pkg::*;
;
  logic        clk, reset, fetch, slow, hi, tbit, nmi, iv, cv, reset_output_pin;
  logic [31:0] word, instr;
  logic [15:0] ip, src, bfw;
  logic [2:0]  len, last_len;
  idec_flags_t flags;
  idec_ctrl_t  ctrl, c;
  int          n_fail, checks_done, cycles;

  idec_pmem idec_pmem_i (.clk(clk), .rst(reset), .fetch(fetch), .slow(slow), .word(word),
    .instr_valid(iv), .instr(instr));
  idec_top idec_top_i (.CLK(clk), .RESET(reset), .INSTR_VALID(iv), .INSTR(instr), .IP(ip),
    .FLAGS(flags), .TEST_BIT(tbit), .SRC_BYTE_WORD(src), .BF_WORD(bfw), .BF_HIGH_SEL(hi),
    .NMI_LEVEL(nmi), .INSTR_LEN(len), .CTRL_VALID(cv), .CTRL(ctrl), .RESET_OUTPUT_PIN_LEVEL(reset_output_pin));

  always #50 clk = ~clk;
  // length is combinational: catch it mid-cycle while the word stands
  always @(negedge clk) begin
    if (iv === 1'b1) last_len = len;
  end
  // hang guard: the run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one fetch through the memory model, fast and slow in turn; result lands in c
  task automatic dec(input logic [31:0] w, input logic [15:0] a, input logic b,
                     input logic [4:0] f, input logic n);
    @(posedge clk);
    fetch <= 1'b1;
    slow  <= ~slow;
    word  <= w;
    ip    <= a;
    src   <= ~a;
    bfw   <= a ^ 16'h5a5a;
    hi    <= a[0];
    tbit  <= b;
    flags <= idec_flags_t'(f);
    nmi   <= n;
    @(posedge clk);
    fetch <= 1'b0;
    repeat (3) begin
      @(posedge clk);
      #1;
      if (cv === 1'b1) break;
    end
    c = ctrl;
    chk("ctrl_valid", cv, 1'b1);
  endtask

  function automatic logic [15:0] tgt(input logic [15:0] a, l, input logic [7:0] r);
    return a + l + {{7{r[7]}}, r, 1'b0};
  endfunction

  task automatic t_len();
    logic [7:0] ops [8] = '{8'h00, 8'h02, 8'hc0, 8'hc2, 8'he2, 8'h9b, 8'hb7, 8'hdb};
    logic [7:0] ln = 8'h5a;
    for (int i = 0; i < 8; i++) begin
      dec({24'h0, ops[i]}, 16'h0100, 1'b0, 5'h0, 1'b1);
      chk("instr_len", last_len, ln[i] ? 3'h4 : 3'h2);
    end
    $display("length test done");
  endtask

  // zero-extend forms c0 and c2, with the top bit of the source byte set then clear
  task automatic t_zext();
    dec(32'h0000_12c0, 16'h0056, 1'b0, 5'h0, 1'b1);
    chk("zext_rr", {c.zero_ext, c.result}, {1'b1, 16'h00a9});
    dec(32'h1234_12c2, 16'h0081, 1'b0, 5'h0, 1'b1);
    chk("zext_rm", {c.zero_ext, c.result}, {1'b1, 16'h007e});
    $display("zero extend test done");
  endtask

  task automatic t_bitbr();
    for (int i = 0; i < 4; i++) begin
      dec({24'hfd_2a34, i[1] ? 8'hba : 8'haa}, 16'h2000, i[0], 5'h0, 1'b1);
      chk("bit_taken", c.branch_taken, i[1] ^ i[0]);
      chk("bit_clear", c.bit_clr_on_one, !i[1] && i[0]);
      chk("bit_set", c.bit_set_on_zero, i[1] && !i[0]);
      if (i[1] ^ i[0]) chk("bit_target", c.target_ip, tgt(16'h2000, 16'h4, 8'hfd));
    end
    $display("bit branch test done");
  endtask

  // entries: opcode high nibble, flags z c v n e, branch expected
  task automatic t_cond();
    logic [9:0] t [18] = '{10'h001, 10'h0a1, 10'h080, 10'h0c1, 10'h109, 10'h148, 10'h185,
      10'h1c4, 10'h211, 10'h241, 10'h041, 10'h042, 10'h28d, 10'h2c5, 10'h300, 10'h341,
      10'h381, 10'h3d1};
    for (int i = 0; i < 18; i++) begin
      dec({16'h0, 8'h80, t[i][9:6], 4'hd}, 16'h0300, 1'b0, t[i][5:1], 1'b1);
      chk("cond_taken", c.branch_taken, t[i][0]);
      if (t[i][0]) chk("rel_target", c.target_ip, tgt(16'h0300, 16'h2, 8'h80));
    end
    $display("condition test done");
  endtask

  task automatic t_flow();
    dec(32'h1234_05e2, 16'h0, 1'b0, 5'h0, 1'b1);
    chk("push_and_call", {c.push_first, c.target_ip}, {1'b1, 16'h1234});
    dec(32'hbeef_05c6, 16'h0, 1'b0, 5'h0, 1'b1);
    chk("context_switch_push", {c.push_first, c.imm}, {1'b1, 16'hbeef});
    dec(32'h0000_05eb, 16'h0, 1'b0, 5'h0, 1'b1);
    chk("return_with_pop_pop", c.pop_reg, 1'b1);
    dec(32'h5678_02da, 16'h0, 1'b0, 5'h0, 1'b1);
    chk("far_call", {c.load_seg, c.target_seg, c.target_ip}, {3'h6, 16'h5678});
    dec(32'h0000_00db, 16'h0, 1'b0, 5'h0, 1'b1);
    chk("far_ret", c.pop_seg, 1'b1);
    dec(32'h0000_000b, 16'h0, 1'b0, 5'h0, 1'b1);
    chk("muldiv", {c.md_implicit, c.iclass}, {1'b1, IDEC_CL_MULDIV});
    $display("call and return test done");
  endtask

  task automatic t_sys();
    logic [7:0] bad [6] = '{8'h8b, 8'hc1, 8'he5, 8'hf5, 8'hf8, 8'h3b};
    dec(32'h0000_b69b, 16'h0, 1'b0, 5'h0, 1'b1);
    chk("trap", {c.sw_trap, c.trap_num}, {1'b1, 7'h5b});
    for (int i = 0; i < 2; i++) begin
      dec(32'h0000_0097, 16'h0, 1'b0, 5'h0, i[0]);
      chk("power_down", c.power_down, !i[0]);
    end
    for (int i = 0; i < 6; i++) begin
      dec({24'h0, bad[i]}, 16'h0, 1'b0, 5'h0, 1'b1);
      chk("undef", {c.undef_trap, c.iclass}, {1'b1, IDEC_CL_TRAP});
    end
    chk("reset_output_pin_before", reset_output_pin, 1'b1);
    dec(32'h0000_00b5, 16'h0, 1'b0, 5'h0, 1'b1);
    @(posedge clk);
    #1;
    chk("reset_output_pin_after", reset_output_pin, 1'b0);
    $display("system test done");
  endtask

  task automatic t_bits();
    logic [3:0] fs [4] = '{4'h7, 4'h8, 4'hb, 4'hc};
    for (int i = 0; i < 16; i++) begin
      dec({24'h0, i[3:0], 3'h7, i[0]}, 16'h0, 1'b0, 5'h0, 1'b1);
      chk("bit_pos", c.bit_pos, i[3:0]);
    end
    for (int i = 0; i < 4; i++) begin
      dec({16'h0, 4'h1, fs[i], 8'h08}, 16'h0, 1'b0, 5'h0, 1'b1);
      chk("sf_mode", c.sf_mode, i == 0 ? IDEC_SF_IMM3 : i < 3 ? IDEC_SF_IND : IDEC_SF_INC);
      chk("ptr_low", c.ptr_r0_r3, 1'b1);
    end
    $display("operand field test done");
  endtask

  // low then high byte; the low address bit steers the byte select
  task automatic t_bf();
    logic [15:0] w;
    logic [7:0]  b;
    for (int i = 0; i < 2; i++) begin
      w = (16'h1230 + i[15:0]) ^ 16'h5a5a;
      b = ((i[0] ? w[15:8] : w[7:0]) & 8'h0f) | 8'ha0;
      dec({16'ha5f0, 8'h00, i[0] ? 8'h1a : 8'h0a}, 16'h1230 + i[15:0], 1'b0, 5'h0, 1'b1);
      chk("bf_result", c.result, i[0] ? {b, w[7:0]} : {w[15:8], b});
    end
    $display("bit field test done");
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {fetch, slow, hi, tbit} = 4'h0;
    nmi = 1'b1;
    word = 32'h0;
    {ip, src, bfw} = 48'h0;
    flags = '0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    chk("reset_output_pin_reset", reset_output_pin, 1'b1);
    t_len();
    t_zext();
    t_bitbr();
    t_cond();
    t_flow();
    t_bits();
    t_bf();
    t_sys();
    print_verdict();
  end
endmodule

bind idec_top idec_top_chk idec_top_chk_i (.CLK(CLK), .RESET(RESET), .INSTR_VALID(INSTR_VALID),
  .INSTR(INSTR), .IP(IP), .FLAGS(FLAGS), .TEST_BIT(TEST_BIT), .SRC_BYTE_WORD(SRC_BYTE_WORD),
  .BF_WORD(BF_WORD), .BF_HIGH_SEL(BF_HIGH_SEL), .NMI_LEVEL(NMI_LEVEL), .INSTR_LEN(INSTR_LEN),
  .CTRL_VALID(CTRL_VALID), .CTRL(CTRL), .RESET_OUTPUT_PIN_LEVEL(RESET_OUTPUT_PIN_LEVEL));
